/* testbench/serial_peer_model.sv */
// Behavioural far-side party: a slave, or a master when the port is a slave
`timescale 1ns/1ps
module serial_peer_model (
    // Role and link setup
    input  wire logic       i_master,
    input  wire logic       i_go,
    input  wire logic       i_pol,
    input  wire logic       i_edge,
    input  wire logic       i_msb,
    input  wire logic [7:0] i_tx,
    // Resolved lines
    input  wire logic       i_sel,
    input  wire logic       i_sck,
    input  wire logic       i_din,
    // Driven lines
    output logic            o_sel,
    output logic            o_sel_oe,
    output logic            o_sck,
    output logic            o_sck_oe,
    output logic            o_dout,
    output logic [7:0]      o_rx
);
    logic [2:0] idx;
    logic       seen_cap;
    logic       last_bit;
    logic       tx_bit;
    initial begin
        {o_sel, o_sck, o_sel_oe, o_sck_oe} = 4'hC;
        {idx, seen_cap, last_bit} = 5'h00;
        o_rx = 8'h00;
    end
    // ==========================================
    // Data: bit order agreed with the port
    assign tx_bit = i_tx[i_msb ? 3'h7 - idx : idx];
    // Unselected, the line shows the inverse of its last bit, never a stale copy
    assign o_dout = i_sel ? ~last_bit : tx_bit;
    always @(negedge i_sel) begin
        idx = 3'h0;
        seen_cap = 1'b0;
    end
    always @(i_sck) begin
        if (i_sel === 1'b0) begin
            if (i_sck === (i_pol == i_edge)) begin
                o_rx = i_msb ? {o_rx[6:0], i_din} : {i_din, o_rx[7:1]};
                last_bit = tx_bit;
                seen_cap = 1'b1;
            end else if (seen_cap) begin
                idx = idx + 3'h1;
            end
        end
    end
    // ==========================================
    // Master role: select, then 16 clock toggles, 800 ns period, still outside frames
    always @(posedge i_go) begin
        if (i_master) begin
            o_sck = ~i_pol;
            o_sck_oe = 1'b1;
            o_sel_oe = 1'b1;
            // Clock settles well before select so no stray edge counts
            #437;
            o_sel = 1'b0;
            #400;
            repeat (16) begin
                o_sck = ~o_sck;
                #400;
            end
            o_sel = 1'b1;
            #400;
            o_sck_oe = 1'b0;
            o_sel_oe = 1'b0;
        end
    end
endmodule // serial_peer_model

/* testbench/test_serial_port.sv */
// Self-checking bench for the four-line serial port against a far-side peer
`timescale 1ns/1ps
module test_serial_port;
    import serial_port_pkg::*;
    // ==========================================
    // Ordinary cases: mode, polarity, edge, order, byte sent, byte returned
    typedef struct packed {
        logic [2:0] mode;
        logic       pol;
        logic       edge_sel;
        logic       msb;
        logic [7:0] tx;
        logic [7:0] rx;
    } row_t;
    localparam int ROWS = 7;
    localparam row_t CASES [ROWS] = '{
        '{MODE_DIV4,  1'b0, 1'b0, 1'b1, 8'hC5, 8'h3A},
        '{MODE_DIV16, 1'b1, 1'b0, 1'b0, 8'h01, 8'h80},
        '{MODE_DIV64, 1'b0, 1'b1, 1'b1, 8'hFF, 8'h00},
        '{MODE_SUB,   1'b1, 1'b1, 1'b0, 8'h96, 8'h69},
        '{MODE_TIMER, 1'b0, 1'b0, 1'b0, 8'h5A, 8'hE7},
        '{MODE_SLAVE, 1'b0, 1'b1, 1'b1, 8'h2C, 8'hD1},
        '{MODE_SLAVE, 1'b1, 1'b0, 1'b0, 8'h73, 8'h8E}
    };
    logic       i_clk, i_rstn, i_wr, i_rd, i_sub_tick, i_timer_match;
    logic [1:0] i_addr;
    logic [7:0] i_wdata, o_rdata, peer_rx, cfg1;
    logic       o_transfer_complete, peer_go, peer_master;
    logic       p_sel, p_sel_oe, p_sck, p_sck_oe, p_dout, sel_line, sck_line;
    pins_in_t   i_pins;
    pins_out_t  o_pins;
    int         miscompares, checks, tick;
    row_t       r;
    // Pull-ups hold released select and clock lines high
    assign sel_line = o_pins.sel_oe ? o_pins.sel_o : (p_sel_oe ? p_sel : 1'b1);
    assign sck_line = o_pins.sck_oe ? o_pins.sck_o : (p_sck_oe ? p_sck : 1'b1);
    assign i_pins = {sel_line, p_dout, sck_line};
    serial_port i_serial_port (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_sub_tick(i_sub_tick), .i_timer_match(i_timer_match), .i_pins(i_pins),
        .o_pins(o_pins), .o_transfer_complete(o_transfer_complete));
    serial_peer_model i_serial_peer_model (.i_master(peer_master), .i_go(peer_go),
        .i_pol(r.pol), .i_edge(r.edge_sel), .i_msb(r.msb), .i_tx(r.rx), .i_sel(sel_line),
        .i_sck(sck_line), .i_din(o_pins.sdo_oe ? o_pins.sdo_o : 1'b1), .o_sel(p_sel),
        .o_sel_oe(p_sel_oe), .o_sck(p_sck), .o_sck_oe(p_sck_oe), .o_dout(p_dout),
        .o_rx(peer_rx));
    always #50 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        tick <= tick + 1;
        i_sub_tick <= (tick % 5 == 0);
        i_timer_match <= (tick % 3 == 0);
    end
    // ==========================================
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic rd_chk(input string what, input logic [1:0] a, input logic [7:0] exp);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk(what, exp, o_rdata);
        @(posedge i_clk);
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        while (o_transfer_complete !== 1'b1 && n < 2000) begin
            @(posedge i_clk);
            n++;
        end
        chk("complete", 8'h01, {7'h00, o_transfer_complete});
    endtask
    task automatic reset_check();
        i_rstn <= 1'b0;
        repeat (16) @(posedge i_clk);
        chk("reset enables", 8'h00, {1'b0, o_pins} & 8'h55);
        i_rstn <= 1'b1;
        @(posedge i_clk);
        rd_chk("control zero", ADDR_CONTROL_ZERO, {MODE_RESET, 5'h00});
        rd_chk("control one", ADDR_CONTROL_ONE, 8'h00);
        rd_chk("unmapped", 2'h3, 8'h00);
    endtask
    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ==========================================
    // Slowest row needs about 500 cycles; the limit leaves a wide margin
    initial begin
        #5_000_000;
        miscompares++;
        finish_test();
    end
    initial begin
        {i_clk, i_rstn, i_wr, i_rd, i_sub_tick, i_timer_match, peer_go} = 7'h00;
        {i_addr, i_wdata, peer_master, miscompares, checks, tick} = '0;
        r = CASES[0];
        @(posedge i_clk);
        reset_check();
        for (int k = 0; k < ROWS; k++) begin
            r = CASES[k];
            peer_master = (r.mode == MODE_SLAVE);
            cfg1 = {2'h0, r.pol, r.edge_sel, r.msb, 3'h4};
            wr(ADDR_CONTROL_ZERO, {r.mode, 5'h00});
            wr(ADDR_CONTROL_ONE, cfg1);
            wr(ADDR_CONTROL_ZERO, {r.mode, 5'h02});
            repeat (8) @(posedge i_clk);
            if (peer_master) begin
                chk("idle lines", 8'h18, {1'b0, o_pins} & 8'h1D);
            end else begin
                chk("idle lines", {5'h07, ~r.pol, 1'b0}, {1'b0, o_pins} & 8'h1F);
            end
            wr(ADDR_SHIFT_DATA, r.tx);
            if (peer_master) begin
                repeat (8) @(posedge i_clk);
                chk("waiting", 8'h00, {7'h00, o_transfer_complete});
                peer_go <= 1'b1;
                @(posedge i_clk);
                peer_go <= 1'b0;
            end
            repeat (3) @(posedge i_clk);
            chk("select", peer_master ? 8'h00 : 8'h44,
                {1'b0, o_pins} & (peer_master ? 8'h44 : 8'h64));
            wr(ADDR_SHIFT_DATA, 8'hA5);
            wait_done();
            rd_chk("data", ADDR_SHIFT_DATA, r.rx);
            rd_chk("flags", ADDR_CONTROL_ONE, cfg1 | 8'h03);
            chk("peer byte", r.tx, peer_rx);
            wr(ADDR_CONTROL_ONE, cfg1);
            rd_chk("cleared", ADDR_CONTROL_ONE, cfg1);
            wr(ADDR_CONTROL_ZERO, {r.mode, 5'h00});
            chk("released", 8'h00, {1'b0, o_pins} & 8'h55);
        end
        // Select pin disabled: the master still runs but leaves the select line alone
        wr(ADDR_CONTROL_ZERO, {MODE_DIV4, 5'h00});
        wr(ADDR_CONTROL_ONE, 8'h08);
        wr(ADDR_CONTROL_ZERO, {MODE_DIV4, 5'h02});
        wr(ADDR_SHIFT_DATA, 8'h81);
        chk("select off", 8'h00, {1'b0, o_pins} & 8'h40);
        wait_done();
        rd_chk("no collision", ADDR_CONTROL_ONE, 8'h09);
        reset_check();
        finish_test();
    end
endmodule // test_serial_port

/* verilog/serial_port.sv */
// Four-line serial port, master or slave, with register port
`timescale 1ns/1ps
// Functional notes
// - Transfers use select, in, out, clock lines
// - Select enable makes select line active
// - Select disabled floats, ignored
// - Enabled idle: input floats, output high
// - Master idle clock is inverse of polarity bit
// - Slave never drives clock line
// - Port disabled releases all four lines
// - Master clocks only after data write
// - Received byte copied whole to data
// - Bit order must match both ends
// - Slave byte waits for master clocks
// - Hardware only sets collision flag
// - Write during transfer flags, is dropped
// - Mode field picks master clock or slave
// - Complete flag set after each byte
// - Edge select with polarity picks capture
// - Order bit: set MSB first
module serial_port
    import serial_port_pkg::*;
(
    // Clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_rstn,
    // Register port
    input  wire logic [1:0]             i_addr,
    input  wire logic [7:0]             i_wdata,
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    output logic      [7:0]             o_rdata,
    // Clock sources for master modes (same clock domain pulses)
    input  wire logic                   i_sub_tick,
    input  wire logic                   i_timer_match,
    // Serial lines
    input  serial_port_pkg::pins_in_t   i_pins,
    output serial_port_pkg::pins_out_t  o_pins,
    // Transfer complete level, usable as interrupt request
    output logic                        o_transfer_complete
);
    import serial_port_pkg::*;

    mode_clock_select_t mode_clock_select;
    logic       port_enable;
    logic       incomplete_flag;
    logic       clock_idle_polarity;
    logic       clock_edge_select;
    logic       bit_order_select;
    logic       select_pin_enable;
    logic       write_collision_flag;
    logic       transfer_complete_flag;
    logic [7:0] shift_data_register;
    logic [7:0] shift_buf;
    logic [3:0] bit_count;
    logic       busy;
    logic [5:0] div_count;
    logic       sck_level;
    logic       timer_half;
    logic       sck_prev;
    logic       sdo_bit;
    pins_in_t   pins_sync;

    // ==========================================
    // Pin synchronisation
    sync_two_ff #(.WIDTH(3)) u_sync (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_async (i_pins),
        .o_sync  (pins_sync)
    );

    function automatic logic [5:0] half_period(input mode_clock_select_t m);
        case (m)
            MODE_DIV4:  half_period = HALF_DIV4;
            MODE_DIV16: half_period = HALF_DIV16;
            MODE_DIV64: half_period = HALF_DIV64;
            default:    half_period = HALF_DIV4;
        endcase
    endfunction

    // ==========================================
    // Derived conditions
    logic is_slave;
    logic is_master;
    logic sel_active;
    logic write_data;
    logic master_tick;
    logic slave_rise;
    logic slave_fall;
    logic capture_on_rise;
    logic lead_edge;
    logic trail_edge;
    logic cap_edge;
    logic shift_edge;
    logic slave_abort;
    logic last_capture;
    logic raw_cap;
    logic cap_delay;

    assign is_slave   = (mode_clock_select == MODE_SLAVE);
    assign is_master  = (mode_clock_select <= MODE_TIMER);
    // Disabled select pin is ignored: slave always selected
    assign sel_active = !select_pin_enable || !pins_sync.sel_i;
    assign write_data = i_wr && (i_addr == ADDR_SHIFT_DATA);
    // Capture edge: polarity 0 -> rise when edge 0; polarity 1 -> rise when edge 1
    assign capture_on_rise = clock_idle_polarity ~^ clock_edge_select;
    assign slave_rise  = pins_sync.sck_i && !sck_prev;
    assign slave_fall  = !pins_sync.sck_i && sck_prev;

    // Master tick toggles internal clock each half period
    always_comb begin
        case (mode_clock_select)
            MODE_SUB:   master_tick = i_sub_tick;
            MODE_TIMER: master_tick = i_timer_match && timer_half;
            default:    master_tick = (div_count == 6'h01);
        endcase
    end

    // Leading and trailing edges as seen on the line
    always_comb begin
        if (is_master) begin
            lead_edge  = busy && master_tick && (sck_level == !clock_idle_polarity);
            trail_edge = busy && master_tick && (sck_level == clock_idle_polarity);
            raw_cap    = capture_on_rise ? (lead_edge && clock_idle_polarity)
                                            || (trail_edge && !clock_idle_polarity)
                                         : (lead_edge && !clock_idle_polarity)
                                            || (trail_edge && clock_idle_polarity);
            cap_edge   = cap_delay;
            shift_edge = (lead_edge || trail_edge) && !raw_cap;
        end else begin
            lead_edge  = 1'b0;
            trail_edge = 1'b0;
            raw_cap    = 1'b0;
            cap_edge   = sel_active && (capture_on_rise ? slave_rise : slave_fall);
            shift_edge = sel_active && (capture_on_rise ? slave_fall : slave_rise);
        end
    end
    assign slave_abort  = is_slave && port_enable && select_pin_enable
                          && pins_sync.sel_i && busy && bit_count != 4'h0;
    assign last_capture = port_enable && busy && cap_edge
                          && (bit_count == BITS_PER_BYTE - 4'h1);

    // ==========================================
    // Register writes: control
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mode_clock_select   <= MODE_RSV7;
            port_enable         <= 1'b0;
            clock_idle_polarity <= 1'b0;
            clock_edge_select   <= 1'b0;
            bit_order_select    <= 1'b0;
            select_pin_enable   <= 1'b0;
        end else if (i_wr && i_addr == ADDR_CONTROL_ZERO) begin
            mode_clock_select <= mode_clock_select_t'(i_wdata[MODE_MSB:MODE_LSB]);
            port_enable       <= i_wdata[PORT_EN_BIT];
        end else if (i_wr && i_addr == ADDR_CONTROL_ONE) begin
            clock_idle_polarity <= i_wdata[IDLE_POL_BIT];
            clock_edge_select   <= i_wdata[EDGE_SEL_BIT];
            bit_order_select    <= i_wdata[ORDER_BIT];
            select_pin_enable   <= i_wdata[SEL_EN_BIT];
        end
    end

    // Flags: hardware set wins over software clear
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            write_collision_flag   <= 1'b0;
            transfer_complete_flag <= 1'b0;
            incomplete_flag        <= 1'b0;
        end else begin
            if (write_data && busy) begin
                write_collision_flag <= 1'b1;
            end else if (i_wr && i_addr == ADDR_CONTROL_ONE) begin
                write_collision_flag <= i_wdata[WCOL_BIT];
            end
            if (last_capture || slave_abort) begin
                transfer_complete_flag <= 1'b1;
            end else if (i_wr && i_addr == ADDR_CONTROL_ONE) begin
                transfer_complete_flag <= i_wdata[TRF_BIT];
            end
            if (slave_abort) begin
                incomplete_flag <= 1'b1;
            end else if (i_wr && i_addr == ADDR_CONTROL_ZERO) begin
                incomplete_flag <= i_wdata[INCOMPL_BIT];
            end
        end
    end

    // ==========================================
    // Shift engine
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            shift_buf           <= SHIFT_DATA_RST;
            shift_data_register <= SHIFT_DATA_RST;
            bit_count           <= 4'h0;
            busy                <= 1'b0;
        end else if (!port_enable) begin
            busy      <= 1'b0;
            bit_count <= 4'h0;
        end else if (write_data && !busy) begin
            // Master starts at once; slave waits for clocks
            shift_buf <= i_wdata;
            busy      <= 1'b1;
            bit_count <= 4'h0;
        end else if (slave_abort) begin
            busy      <= 1'b0;
            bit_count <= 4'h0;
        end else if (busy && cap_edge) begin
            if (bit_order_select) begin
                shift_buf <= {shift_buf[6:0], pins_sync.sdi_i};
            end else begin
                shift_buf <= {pins_sync.sdi_i, shift_buf[7:1]};
            end
            if (last_capture) begin
                shift_data_register <= bit_order_select
                    ? {shift_buf[6:0], pins_sync.sdi_i}
                    : {pins_sync.sdi_i, shift_buf[7:1]};
                busy      <= is_slave;
                bit_count <= 4'h0;
            end else begin
                bit_count <= bit_count + 4'h1;
            end
        end
    end

    // Output bit: first bit ready before the first capture
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sdo_bit <= 1'b1;
        end else if (write_data && !busy) begin
            sdo_bit <= bit_order_select ? i_wdata[7] : i_wdata[0];
        end else if (busy && shift_edge && bit_count != 4'h0) begin
            sdo_bit <= bit_order_select ? shift_buf[7] : shift_buf[0];
        end else if (!busy) begin
            sdo_bit <= 1'b1;
        end
    end

    // ==========================================
    // Master clock generation
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            div_count  <= 6'h00;
            sck_level  <= 1'b1;
            timer_half <= 1'b0;
        end else if (!busy || !is_master) begin
            div_count  <= half_period(mode_clock_select);
            sck_level  <= clock_idle_polarity ? 1'b0 : 1'b1;
            timer_half <= 1'b0;
        end else begin
            if (i_timer_match) begin
                timer_half <= !timer_half;
            end
            if (master_tick) begin
                div_count <= half_period(mode_clock_select);
                sck_level <= !sck_level;
            end else if (div_count > 6'h01) begin
                div_count <= div_count - 6'h01;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sck_prev  <= 1'b1;
            cap_delay <= 1'b0;
        end else begin
            sck_prev  <= pins_sync.sck_i;
            // Master samples a cycle late: the data pin lags its own clock by the synchroniser
            cap_delay <= is_master && raw_cap;
        end
    end

    // ==========================================
    // Pin drive
    always_comb begin
        o_pins.sdi_oe = 1'b0;
        o_pins.sdo_oe = port_enable;
        o_pins.sdo_o  = sdo_bit;
        o_pins.sck_oe = port_enable && is_master;
        o_pins.sck_o  = sck_level;
        // Master drives select low during a byte
        o_pins.sel_oe = port_enable && select_pin_enable && is_master;
        o_pins.sel_o  = !busy;
    end

    // ==========================================
    // Register reads
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                ADDR_CONTROL_ZERO: o_rdata <= {mode_clock_select, 3'h0,
                                               port_enable, incomplete_flag};
                ADDR_CONTROL_ONE:  o_rdata <= {2'h0, clock_idle_polarity,
                                               clock_edge_select, bit_order_select,
                                               select_pin_enable, write_collision_flag,
                                               transfer_complete_flag};
                ADDR_SHIFT_DATA:   o_rdata <= shift_data_register;
                default:           o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end
    assign o_transfer_complete = transfer_complete_flag;

    // ==========================================
    // Checks
    AST_COLLISION_SET: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (write_data && busy) |=> write_collision_flag)
        else $error("collision flag not set");
    AST_COLLISION_KEEPS_BUF: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (write_data && busy && port_enable && !cap_edge && !slave_abort) |=> $stable(shift_buf))
        else $error("collided write altered buffer");
    AST_COLLISION_STICKY: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (write_collision_flag && !(i_wr && i_addr == ADDR_CONTROL_ONE)) |=> write_collision_flag)
        else $error("collision flag cleared by hardware");
    AST_COMPLETE_SET: assert property (@(posedge i_clk) disable iff (!i_rstn)
        last_capture |=> transfer_complete_flag && !busy == !is_slave)
        else $error("complete flag missing after byte");
    AST_SLAVE_NO_CLOCK: assert property (@(posedge i_clk) disable iff (!i_rstn)
        is_slave |-> !o_pins.sck_oe)
        else $error("slave drives clock");
    AST_DISABLED_RELEASE: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !port_enable |-> !o_pins.sck_oe && !o_pins.sdo_oe && !o_pins.sel_oe)
        else $error("disabled port drives a line");
    AST_IDLE_CLOCK: assert property (@(posedge i_clk) disable iff (!i_rstn)
        ($past(!busy) && !busy && is_master) |-> (sck_level == !$past(clock_idle_polarity)))
        else $error("idle clock wrong level");
    AST_DATA_LATCH: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !last_capture |=> $stable(shift_data_register))
        else $error("data register changed mid byte");
    AST_IDLE_OUT_HIGH: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (!busy && !$past(busy) && !$past(write_data)) |-> sdo_bit)
        else $error("idle output not high");
endmodule // serial_port

/* verilog/serial_port_pkg.sv */
// Package: register map, field positions, modes and timing of the four-line serial port
package serial_port_pkg;
    // ==========================================
    // Register indices on the plain register port
    localparam logic [1:0] ADDR_CONTROL_ZERO = 2'h0;
    localparam logic [1:0] ADDR_CONTROL_ONE  = 2'h1;
    localparam logic [1:0] ADDR_SHIFT_DATA   = 2'h2;
    // ==========================================
    // Field positions, control zero
    localparam int MODE_MSB     = 7;
    localparam int MODE_LSB     = 5;
    localparam int PORT_EN_BIT  = 1;
    localparam int INCOMPL_BIT  = 0;
    // Field positions, control one
    localparam int IDLE_POL_BIT = 5;
    localparam int EDGE_SEL_BIT = 4;
    localparam int ORDER_BIT    = 3;
    localparam int SEL_EN_BIT   = 2;
    localparam int WCOL_BIT     = 1;
    localparam int TRF_BIT      = 0;
    // ==========================================
    // Reset values
    localparam logic [2:0] MODE_RESET     = 3'h7;
    localparam logic [7:0] SHIFT_DATA_RST = 8'h00;
    // ==========================================
    // Mode codes
    typedef enum logic [2:0] {
        MODE_DIV4   = 3'b000,
        MODE_DIV16  = 3'b001,
        MODE_DIV64  = 3'b010,
        MODE_SUB    = 3'b011,
        MODE_TIMER  = 3'b100,
        MODE_SLAVE  = 3'b101,
        MODE_RSV6   = 3'b110,
        MODE_RSV7   = 3'b111
    } mode_clock_select_t;
    // Master bit clock divisors (system clocks per half serial period)
    localparam logic [5:0] HALF_DIV4  = 6'h02;
    localparam logic [5:0] HALF_DIV16 = 6'h08;
    localparam logic [5:0] HALF_DIV64 = 6'h20;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // Link clock period in the bench, ns, and system clock period, ns
    localparam int LINK_PERIOD_NS = 800;
    localparam int SYS_PERIOD_NS  = 100;
    localparam int LINK_CYCLES    = LINK_PERIOD_NS / SYS_PERIOD_NS;
    // ==========================================
    // Pin bundle: input, output and enable of a line
    typedef struct packed {
        logic sel_oe;
        logic sel_o;
        logic sdo_oe;
        logic sdo_o;
        logic sck_oe;
        logic sck_o;
        logic sdi_oe;
    } pins_out_t;
    typedef struct packed {
        logic sel_i;
        logic sdi_i;
        logic sck_i;
    } pins_in_t;
endpackage

/* verilog/sync_two_ff.sv */
// Two-flop synchroniser for a bundle of asynchronous pin levels
`timescale 1ns/1ps
module sync_two_ff #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    // Levels
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] first_stage;

    initial begin
        if (WIDTH < 1) begin
            $error("sync_two_ff: WIDTH must be positive");
        end
    end

    // First stage feeds only the second stage
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            first_stage <= '0;
            o_sync      <= '0;
        end else begin
            first_stage <= i_async;
            o_sync      <= first_stage;
        end
    end
endmodule // sync_two_ff
